// ==== src/abc_consts.svh ====
`ifndef ABC_CONSTS_SVH
`define ABC_CONSTS_SVH

// register location and field positions
`define ABC_AUX_ADDR 8'h8e
`define ABC_BIT_DIS 0
`define ABC_BIT_EXT 1
`define ABC_BIT_SZ_LO 2
`define ABC_BIT_SZ_HI 3
`define ABC_BIT_STR 5

// reset values
`define ABC_RST_DIS 1'h0
`define ABC_RST_STR 1'h0
`define ABC_RST_SZ 2'h0
`define ABC_RST_EXT 1'h0

// latch strobe period in oscillator clocks
`define ABC_ALE_DIV 3'h6
`define ABC_ALE_DIV_X2 3'h3

// read and write strobe length in clock periods
`define ABC_STROBE_SHORT 5'h06
`define ABC_STROBE_LONG 5'h1e

// one step of the expanded internal ram size
`define ABC_RAM_UNIT 11'h100

`endif

// ==== src/abc_pkg.sv ====
package abc_pkg;

  typedef enum logic {
    ABC_IDLE,
    ABC_STROBE
  } abc_xfer_e;

  typedef struct packed {
    logic strobe_disable;
    logic strobe_stretch;
    logic [1:0] ram_size;
    logic external_memory_select;
    logic sel_loaded;
    logic [2:0] div_cnt;
    abc_xfer_e xfer;
    logic [4:0] xfer_cnt;
    logic xfer_wr;
    logic [7:0] rdata;
    logic ale;
    logic ale_oe;
    logic rd_n;
    logic wr_n;
    logic done;
  } abc_state_s;

  typedef struct packed {
    logic ale;
    logic ale_oe;
    logic rd_n;
    logic wr_n;
  } abc_pins_s;

endpackage

// ==== src/abc_aux_ctrl.sv ====
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "abc_consts.svh"

// Function
// - bit 0 of the auxiliary register disables the address latch strobe
// - when disabled, strobe still pulses for data moves, constant moves, external fetches
// - suppressed strobe pin is released, left weakly pulled high
// - enabled strobe runs continuously at oscillator/6, or oscillator/3 in X2 mode
// - bit 5 sets read/write strobe length: 6 clocks clear, 30 clocks set
// - bits 3:2 select expanded ram size 256, 512, 768 or 1024 bytes
// - bit 1 routes external data moves: clear internal ram, set external memory
// - after power-up, bit 1 is loaded from the hardware security byte
// - reserved bits 7, 6, 4 read undetermined (this block reads them as zero); software never writes ones
module abc_aux_ctrl (
  input wire logic sys_clk_i, // 200 MHz oscillator clock
  input wire logic nrst_i, // async reset, active low
  input wire logic [7:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // register write data
  input wire logic wr_i, // register write strobe
  input wire logic rd_i, // register read strobe
  output logic [7:0] rdata_o, // read data, cycle after rd_i
  input wire logic x2_mode_i, // X2 mode active
  input wire logic hsb_ext_i, // security byte bit, external memory default
  input wire logic movx_req_i, // external data move request pulse
  input wire logic movx_wr_i, // request is a write
  input wire logic code_constant_move_i, // code constant move in progress
  input wire logic ext_fetch_i, // external instruction fetch in progress
  output logic movx_done_o, // data move finished pulse
  output logic route_ext_o, // data moves go to external memory
  output logic [1:0] ram_size_o, // expanded ram size code
  output logic [10:0] ram_limit_o, // expanded ram size in bytes
  output abc_pkg::abc_pins_s pins_o // latch strobe and read/write strobes
);

  abc_pkg::abc_state_s s;
  abc_pkg::abc_state_s next_s;
  logic [2:0] div_lim;
  logic [4:0] len;
  logic access;
  logic hit_wr;

  always_comb begin
    div_lim = x2_mode_i ? `ABC_ALE_DIV_X2 : `ABC_ALE_DIV;
    len = s.strobe_stretch ? `ABC_STROBE_LONG : `ABC_STROBE_SHORT;
    access = code_constant_move_i | ext_fetch_i | movx_req_i | (s.xfer == abc_pkg::ABC_STROBE);
    hit_wr = wr_i && (addr_i == `ABC_AUX_ADDR);
  end

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.rdata = 8'h00;
    if (!s.sel_loaded) begin
      next_s.sel_loaded = 1'b1;
      next_s.external_memory_select = hsb_ext_i;
    end
    if (hit_wr) begin
      next_s.strobe_disable = wdata_i[`ABC_BIT_DIS];
      next_s.external_memory_select = wdata_i[`ABC_BIT_EXT];
      next_s.ram_size = wdata_i[`ABC_BIT_SZ_HI:`ABC_BIT_SZ_LO];
      next_s.strobe_stretch = wdata_i[`ABC_BIT_STR];
    end
    if (rd_i && (addr_i == `ABC_AUX_ADDR)) begin
      next_s.rdata[`ABC_BIT_DIS] = s.strobe_disable;
      next_s.rdata[`ABC_BIT_EXT] = s.external_memory_select;
      next_s.rdata[`ABC_BIT_SZ_HI:`ABC_BIT_SZ_LO] = s.ram_size;
      next_s.rdata[`ABC_BIT_STR] = s.strobe_stretch;
    end
    if (s.div_cnt >= div_lim - 3'h1) begin
      next_s.div_cnt = 3'h0;
    end else begin
      next_s.div_cnt = s.div_cnt + 3'h1;
    end
    next_s.ale = (next_s.div_cnt == 3'h0);
    // pin released unless enabled or an external access runs
    next_s.ale_oe = !s.strobe_disable || access;
    unique case (s.xfer)
      abc_pkg::ABC_IDLE: begin
        if (movx_req_i) begin
          // internal ram needs no external strobes
          if (s.external_memory_select) begin
            next_s.xfer = abc_pkg::ABC_STROBE;
            next_s.xfer_cnt = len - 5'h01;
            next_s.xfer_wr = movx_wr_i;
            next_s.rd_n = movx_wr_i;
            next_s.wr_n = !movx_wr_i;
          end else begin
            next_s.done = 1'b1;
          end
        end
      end
      abc_pkg::ABC_STROBE: begin
        // strobe held for the selected length
        if (s.xfer_cnt == 5'h00) begin
          next_s.xfer = abc_pkg::ABC_IDLE;
          next_s.rd_n = 1'b1;
          next_s.wr_n = 1'b1;
          next_s.done = 1'b1;
        end else begin
          next_s.xfer_cnt = s.xfer_cnt - 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '{strobe_disable: `ABC_RST_DIS, strobe_stretch: `ABC_RST_STR,
             ram_size: `ABC_RST_SZ, external_memory_select: `ABC_RST_EXT,
             sel_loaded: 1'b0, div_cnt: 3'h0, xfer: abc_pkg::ABC_IDLE,
             xfer_cnt: 5'h00, xfer_wr: 1'b0, rdata: 8'h00, ale: 1'b0,
             ale_oe: 1'b1, rd_n: 1'b1, wr_n: 1'b1, done: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    rdata_o = s.rdata;
    movx_done_o = s.done;
    route_ext_o = s.external_memory_select;
    ram_size_o = s.ram_size;
    ram_limit_o = `ABC_RAM_UNIT * ({9'h000, s.ram_size} + 11'h001);
    // weak pull-up shows a high level, so the driven value is high too
    pins_o.ale = s.ale_oe ? s.ale : 1'b1;
    pins_o.ale_oe = s.ale_oe;
    pins_o.rd_n = s.rd_n;
    pins_o.wr_n = s.wr_n;
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // helper: counts low cycles of the active strobe
  logic [4:0] low_cnt;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_cnt <= 5'h00;
    end else if (!s.rd_n || !s.wr_n) begin
      low_cnt <= low_cnt + 5'h01;
    end else begin
      low_cnt <= 5'h00;
    end
  end

  sequence strobe_begin;
    movx_req_i && s.xfer == abc_pkg::ABC_IDLE && s.external_memory_select && !wr_i;
  endsequence

  sequence short_strobe;
    (!s.rd_n || !s.wr_n) [*6] ##1 (s.rd_n && s.wr_n && s.done);
  endsequence

  a_short_strobe_len: assert property (
    strobe_begin and (!s.strobe_stretch) |=> short_strobe)
    else $error("short strobe not 6 cycles");

  // low_cnt holds the finished strobe length in the done cycle
  a_long_strobe_len: assert property (
    s.done && low_cnt != 5'h00 |-> low_cnt == `ABC_STROBE_SHORT || low_cnt == `ABC_STROBE_LONG)
    else $error("strobe length neither 6 nor 30");

  a_strobe_cap: assert property (
    low_cnt <= 5'h1e)
    else $error("strobe exceeds 30 cycles");

  a_internal_route: assert property (
    movx_req_i && s.xfer == abc_pkg::ABC_IDLE && !s.external_memory_select
      |=> s.rd_n && s.wr_n && movx_done_o)
    else $error("internal move drove external strobes");

  sequence ale_normal_window;
    (!x2_mode_i && !s.strobe_disable) [*6];
  endsequence

  sequence ale_x2_window;
    (x2_mode_i && !s.strobe_disable) [*3];
  endsequence

  // only a driven pulse opens the window: a released pin reads high and would fake one
  a_ale_period: assert property (
    pins_o.ale && pins_o.ale_oe ##0 ale_normal_window |=> pins_o.ale && !$past(pins_o.ale, 1)
      && !$past(pins_o.ale, 2) && !$past(pins_o.ale, 3) && !$past(pins_o.ale, 4) && !$past(pins_o.ale, 5))
    else $error("latch strobe period not 6");

  a_ale_period_x2: assert property (
    pins_o.ale && pins_o.ale_oe ##0 ale_x2_window |=> pins_o.ale && !$past(pins_o.ale, 1)
      && !$past(pins_o.ale, 2))
    else $error("latch strobe period not 3 in x2 mode");

  a_ale_driven: assert property (
    !s.strobe_disable && !$past(hit_wr) |-> ##1 pins_o.ale_oe)
    else $error("latch strobe not driven while enabled");

  a_ale_released: assert property (
    s.strobe_disable && !access && !hit_wr |=> !pins_o.ale_oe && pins_o.ale)
    else $error("latch strobe pin driven while suppressed");

  a_ale_on_access: assert property (
    (code_constant_move_i || ext_fetch_i) |=> pins_o.ale_oe)
    else $error("latch strobe suppressed during access");

  a_size_bytes: assert property (
    s.ram_size == 2'h3 |-> ram_limit_o == 11'h400)
    else $error("ram size wrong");

  a_rd_cfg_write: assert property (
    hit_wr |=> s.strobe_disable == $past(wdata_i[0]) && ram_size_o == $past(wdata_i[3:2]))
    else $error("register write not taken");

  a_reserved_zero: assert property (
    rd_i |=> rdata_o[7:6] == 2'h0 && rdata_o[4] == 1'b0)
    else $error("reserved bits not zero");

  // a write in the very first cycle takes priority over the security default
  a_hsb_load: assert property (
    !s.sel_loaded && !hit_wr |=> route_ext_o == $past(hsb_ext_i))
    else $error("security default not loaded");

  sequence strobe_end;
    (!s.rd_n || !s.wr_n) ##1 (s.rd_n && s.wr_n);
  endsequence

  a_strobe_end_done: assert property (
    strobe_end |-> movx_done_o)
    else $error("move done missing at strobe end");

  // memory must never see read and write at once
  a_strobe_one_low: assert property (
    s.rd_n || s.wr_n)
    else $error("read and write strobes low together");

  a_read_strobe: assert property (
    strobe_begin ##0 !movx_wr_i
      |=> !s.rd_n && s.wr_n)
    else $error("external read did not drive read strobe");

  a_write_strobe: assert property (
    strobe_begin ##0 movx_wr_i
      |=> s.rd_n && !s.wr_n)
    else $error("external write did not drive write strobe");

  a_rd_hold: assert property (
    !s.rd_n && s.xfer_cnt != 5'h00 |=> !s.rd_n)
    else $error("read strobe ended early");

  a_wr_hold: assert property (
    !s.wr_n && s.xfer_cnt != 5'h00 |=> !s.wr_n)
    else $error("write strobe ended early");

  a_route_write: assert property (
    hit_wr |=> route_ext_o == $past(wdata_i[`ABC_BIT_EXT]))
    else $error("route select write not taken");

  a_stretch_write: assert property (
    hit_wr |=> s.strobe_stretch == $past(wdata_i[`ABC_BIT_STR]))
    else $error("stretch write not taken");

  a_ale_pull_high: assert property (
    !pins_o.ale_oe |-> pins_o.ale)
    else $error("released latch pin not high");

  // the pin is taken back one cycle after an access starts
  a_ale_lag: assert property (
    s.strobe_disable && access |=> pins_o.ale_oe)
    else $error("latch strobe not driven for access");

  a_div_range: assert property (
    s.div_cnt < `ABC_ALE_DIV)
    else $error("latch divider out of range");

  a_size_default: assert property (
    s.ram_size == 2'h0 |-> ram_limit_o == 11'h100)
    else $error("ram size 256 wrong");

  a_size_512: assert property (
    s.ram_size == 2'h1 |-> ram_limit_o == 11'h200)
    else $error("ram size 512 wrong");

  a_size_768: assert property (
    s.ram_size == 2'h2 |-> ram_limit_o == 11'h300)
    else $error("ram size 768 wrong");

  // read data stands for one cycle only, so a stale value cannot be misread
  a_rdata_idle: assert property (
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data not cleared");

  a_unmapped_read: assert property (
    rd_i && addr_i != `ABC_AUX_ADDR |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");

endmodule

`default_nettype wire

// ==== test/abc_ext_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module abc_ext_mem (
  input wire logic clk_i, // system clock
  input wire abc_pkg::abc_pins_s pins_i, // strobes from the block
  output int len_o // length of the last strobe
);
  int cnt = 0;
  always @(posedge clk_i) begin
    if (!pins_i.rd_n || !pins_i.wr_n) begin
      cnt <= cnt + 1;
    end else if (cnt != 0) begin
      len_o <= cnt;
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, x2_mode_i = 0, hsb_ext_i = 1;
  logic movx_req_i = 0, movx_wr_i = 0, code_constant_move_i = 0, ext_fetch_i = 0;
  logic [7:0] addr_i = 8'h8e, wdata_i = 8'h00, rdata_o;
  logic movx_done_o, route_ext_o;
  logic [1:0] ram_size_o;
  logic [10:0] ram_limit_o;
  abc_pkg::abc_pins_s pins_o;
  int errors = 0, checked = 0, mlen, m_reg, n, seed = 32'h707b;
  abc_aux_ctrl dut_u (.sys_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .x2_mode_i,
    .hsb_ext_i, .movx_req_i, .movx_wr_i, .code_constant_move_i, .ext_fetch_i, .movx_done_o, .route_ext_o,
    .ram_size_o, .ram_limit_o, .pins_o);
  abc_ext_mem mem_u (.clk_i(sys_clk_i), .pins_i(pins_o), .len_o(mlen));
  int dly;
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge sys_clk_i);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    cyc(1);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    cyc(1);
    wr_i <= 0;
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] e);
    cyc(1);
    rd_i <= 1;
    addr_i <= a;
    cyc(1);
    rd_i <= 0;
    #1 chk("rdata", rdata_o, e);
    cyc(1);
  endtask
  // waits for one latch pulse, then counts clocks to the next
  task automatic per(output int p);
    p = 0;
    do begin cyc(1); #1 p++; end while (pins_o.ale !== 1 && p < 20);
    p = 0;
    do begin cyc(1); #1 p++; end while (pins_o.ale !== 1 && p < 20);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  initial begin
    #100us;
    errors++;
    give_verdict();
  end
  initial begin
    cyc(4);
    nrst_i <= 1;
    cyc(2);
    #1 chk("route", route_ext_o, 1);
    chk("limit", ram_limit_o, 256);
    rdc(8'h8e, 8'h02);
    for (n = 0; n < 4; n++) begin
      m_reg = (rnd() & 8'h23) | (n << 2);
      wr(8'h8e, m_reg[7:0]);
      #1 chk("size", ram_size_o, n);
      chk("limit", ram_limit_o, (n + 1) * 256);
      chk("route", route_ext_o, m_reg[1]);
      rdc(8'h8e, m_reg[7:0]);
    end
    wr(8'h8f, 8'h00);
    rdc(8'h8f, 8'h00);
    rdc(8'h8e, m_reg[7:0]);
    $display("test registers done");
    for (n = 0; n < 5; n++) begin
      wr(8'h8e, n == 4 ? 8'h00 : (n[1] ? 8'h22 : 8'h02));
      movx_req_i <= 1;
      movx_wr_i <= n[0];
      cyc(1);
      movx_req_i <= 0;
      #1 chk("wr_n", pins_o.wr_n, !(n[0] && n < 4));
      dly = 0;
      while (movx_done_o !== 1 && dly < 40) begin cyc(1); #1 dly++; end
      chk("move length", dly, n == 4 ? 0 : (n[1] ? 30 : 6));
      cyc(1);
      #1 if (n < 4) chk("far side length", mlen, n[1] ? 30 : 6);
    end
    $display("test data moves done");
    wr(8'h8e, 8'h00);
    for (n = 0; n < 2; n++) begin
      x2_mode_i <= n[0];
      per(dly);
      per(dly);
      chk("ale period", dly, n ? 3 : 6);
      cyc(1);
    end
    wr(8'h8e, 8'h01);
    for (n = 0; n < 2; n++) begin
      cyc(4);
      #1 chk("ale_oe", pins_o.ale_oe, 0);
      chk("ale", pins_o.ale, 1);
      cyc(1);
      code_constant_move_i <= !n[0];
      ext_fetch_i <= n[0];
      cyc(2);
      #1 chk("ale_oe", pins_o.ale_oe, 1);
      per(dly);
      chk("ale active", dly <= 6, 1);
      cyc(1);
      code_constant_move_i <= 0;
      ext_fetch_i <= 0;
    end
    $display("test latch strobe done");
    hsb_ext_i <= 0;
    nrst_i <= 0;
    cyc(2);
    nrst_i <= 1;
    cyc(2);
    #1 chk("route", route_ext_o, 0);
    chk("limit", ram_limit_o, 256);
    rdc(8'h8e, 8'h00);
    $display("test reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
